// ### rtl/trace_pkg.sv
// constants, types and register map of the trace capture block.
// assumes a 25 MHz core clock and a synchronous active-high reset.
//
// Overview of operation
// (R1) tracing off: the final state only raises a breakpoint, nothing stored
// (R2) session end or final state with tracing off clears arm, back to idle
// (R3) trace store is 64 lines of 20 bits, written circularly
// (R4) software reads lines through two 16-bit window registers
// (R5) line count register rises after every line stored, holding at 64 once full
// (R6) nothing is recorded while the background debug controller is active
// (R7) window reads while armed give invalid data, read pointer kept
// (R8) end alignment: record from arming until the final state ends it
// (R9) begin alignment: recording starts at the opcode of the trigger
// (R10) end alignment or begin-aligned software trigger: storing starts two cycles later
// (R11) begin alignment: store only after final state, stay armed for 64 lines
// (R12) begin alignment: a trigger on a flow change stores that entry
// (R13) begin alignment with tags: breakpoint comes at session completion
// (R14) end alignment: wrap and overwrite oldest, stop and disarm at final
// (R15) end alignment: the flow change at the trigger is not stored
// (R16) mode field picks one of four modes, source bit enables tracing
// (R17) normal mode stores taken branch sources, jump/return destinations, vectors
// (R18) plain branches, subroutine branch, background, direct jumps not stored
// (R19) normal entries hold 18 address bits plus source/destination flags
// (R20) a flow change destination is stored even when an interrupt follows
// (R21) loop mode drops a source equal to the last stored address only
// (R22) detail mode stores address and data of every non-fetch access
// (R23) compressed mode stores every opcode PC, full PC on 64-byte crossing
// (R24) detail entries take two lines, count rises twice, 32 entries
// (R25) high window read then low window read completes one line
package trace_pkg;

   // ==========================================================
   // geometry
   localparam int TRACE_LINES = 64;
   localparam int LINE_WIDTH = 20;
   localparam int PTR_BITS = 6;
   localparam int PC_MSB = 17;
   localparam int PC_PAGE_LSB = 6;
   localparam logic [6:0] COUNT_FULL = 7'h40;
   localparam logic [6:0] COUNT_RESET = 7'h00;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
   localparam logic [7:0] OFS_TRACE_CONTROL = 8'h04;
   localparam logic [7:0] OFS_WINDOW_HIGH = 8'h08;
   localparam logic [7:0] OFS_WINDOW_LOW = 8'h0c;
   localparam logic [7:0] OFS_LINE_COUNT = 8'h10;

   // ==========================================================
   // field positions and reset values
   localparam int BIT_ARM = 7;
   localparam int BIT_SOFTWARE_TRIGGER = 6;
   localparam int BIT_ALIGN = 2;
   localparam int BIT_SOURCE = 3;
   localparam logic [1:0] INFO_BASE = 2'h0;
   localparam logic [1:0] INFO_THREE = 2'h3;
   localparam logic [15:0] INVALID_READ = 16'hffff;
   localparam logic ALIGN_RESET = 1'h0;
   localparam logic SOURCE_RESET = 1'h0;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_STORE = 2'b10
   } state_type;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_LOOP = 2'b01,
      MODE_DETAIL = 2'b10,
      MODE_COMPRESSED = 2'b11
   } mode_type;

   typedef enum logic [2:0] {
      COF_NONE = 3'b000,
      COF_COND_TAKEN = 3'b001,
      COF_INDEXED = 3'b010,
      COF_RETURN = 3'b011,
      COF_VECTOR = 3'b100,
      COF_BDM_VECTOR = 3'b101,
      COF_UNCOND = 3'b110,
      COF_DIRECT = 3'b111
   } cof_class_type;

endpackage: trace_pkg

// ### rtl/trace_ram_if.sv
// write and read signals between the capture logic and its line store.
// assumes one clock; the store samples on the rising edge.
interface trace_ram_if #(
   parameter int WIDTH = 20,
   parameter int ABITS = 6
);
   logic we;
   logic we2;
   logic [ABITS-1:0] wrAddr;
   logic [WIDTH-1:0] wrData;
   logic [WIDTH-1:0] wrData2;
   logic [ABITS-1:0] rdAddr;
   logic [WIDTH-1:0] rdData;

   modport writer(output we, we2, wrAddr, wrData, wrData2, rdAddr,
      input rdData);
   modport store(input we, we2, wrAddr, wrData, wrData2, rdAddr,
      output rdData);
endinterface: trace_ram_if

// ### rtl/trace_ram.sv
// circular line store: one or two consecutive lines written per cycle.
// assumes the writer never asks for two lines at the same address.
module trace_ram #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 64,
   parameter int ABITS = 6
) (
   // clock
   input wire logic core_clk,
   // line access
   trace_ram_if.store port
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================
   // storage; the second line lands after the first, wrapping
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         mem[port.wrAddr] <= port.wrData;
      end
      if (port.we2) begin
         mem[ABITS'(port.wrAddr + 1'b1)] <= port.wrData2;
      end
   end

   assign port.rdData = mem[port.rdAddr];

endmodule: trace_ram

// ### rtl/debug_trace_capture.sv
// trace capture of the on-chip debug module, with a wishbone slave.
// assumes the sequencer pulses finalEnter for one cycle on entry and the
// cpu presents one flow change, access or opcode per cycle at most.
module debug_trace_capture (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // state sequencer
   input wire logic finalEnter,
   // cpu core
   input wire logic backgroundDebugActive,
   input wire logic cofValid,
   input wire trace_pkg::cof_class_type cofClass,
   input wire logic [17:0] cofAddr,
   input wire logic accessValid,
   input wire logic accessFetch,
   input wire logic accessByte,
   input wire logic accessRead,
   input wire logic [17:0] accessAddr,
   input wire logic [15:0] accessData,
   input wire logic opcodeValid,
   input wire logic [17:0] opcodePc,
   // debug status
   output logic armed,
   output logic breakpointRequest
);
   import trace_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      state_type state;
      logic pendStart;
      mode_type mode;
      logic source;
      logic align;
      logic [6:0] lineCount;
      logic [5:0] wrPtr;
      logic [5:0] rdPtr;
      logic highRead;
      logic [17:0] lastAddr;
      logic lastValid;
      logic [17:0] pcBase;
      logic baseValid;
      logic [17:0] slots;
      logic [1:0] slotCnt;
      logic ack;
      logic [31:0] dat;
      logic brk;
      logic armedFlag;
   } regs_type;

   regs_type r;
   regs_type next_r;
   logic busReq;
   logic busWrite;
   logic busRead;
   logic isArmed;
   logic storeGo;
   logic endSession;
   logic wr1;
   logic wr2;
   logic [19:0] lineA;
   logic [19:0] lineB;
   logic [7:0] cnt;
   logic [15:0] rdValue;

   trace_ram_if #(.WIDTH(LINE_WIDTH), .ABITS(PTR_BITS)) ram();

   trace_ram #(
      .WIDTH(LINE_WIDTH),
      .DEPTH(TRACE_LINES),
      .ABITS(PTR_BITS)
   ) store_u (
      .core_clk(core_clk),
      .port(ram)
   );

   // ==========================================================
   // flow change decode
   function automatic logic cof_is_stored(cof_class_type c);
      case (c)
         COF_COND_TAKEN, COF_INDEXED, COF_RETURN, COF_VECTOR:
            cof_is_stored = 1'b1; // R17
         default:
            cof_is_stored = 1'b0; // R18
      endcase
   endfunction: cof_is_stored

   function automatic logic cof_is_source(cof_class_type c);
      cof_is_source = (c == COF_COND_TAKEN);
   endfunction: cof_is_source

   assign busReq = cyc_i & stb_i & ~r.ack;
   assign busWrite = busReq & we_i & sel_i[0];
   assign busRead = busReq & ~we_i;
   assign isArmed = (r.state != ST_IDLE);

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      wr1 = 1'b0;
      wr2 = 1'b0;
      lineA = '0;
      lineB = '0;
      endSession = 1'b0;
      rdValue = 16'h0000;
      next_r.ack = busReq;
      next_r.brk = 1'b0;
      // begin alignment stores from the trigger cycle itself
      storeGo = r.source & ~backgroundDebugActive & // R6
         ((r.state == ST_STORE) |
         (r.state == ST_WAIT & finalEnter & r.align)); // R9 R11 R12 R13
      // the flow change at an end-aligned trigger is dropped
      if (r.state == ST_STORE && !r.align && finalEnter) begin
         storeGo = 1'b0; // R15
      end

      // line builders; normal and loop modes share one
      if (storeGo) begin
         case (r.mode) // R16
            MODE_NORMAL, MODE_LOOP: begin
               if (cofValid && cof_is_stored(cofClass)) begin
                  // destination taken at completion, even before an isr
                  wr1 = 1'b1; // R20
                  lineA = {~cof_is_source(cofClass),
                     cofClass == COF_VECTOR, cofAddr}; // R19
                  if (r.mode == MODE_LOOP && cof_is_source(cofClass) &&
                        r.lastValid && r.lastAddr == cofAddr) begin
                     wr1 = 1'b0; // R21
                  end
                  if (wr1) begin
                     next_r.lastAddr = cofAddr; // R21
                     next_r.lastValid = 1'b1;
                  end
               end
            end
            MODE_DETAIL: begin
               if (accessValid && !accessFetch) begin
                  wr1 = 1'b1; // R22
                  wr2 = 1'b1; // R24
                  lineA = {accessByte, accessRead, accessAddr};
                  lineB = {4'h0, accessByte ?
                     {8'h00, accessData[7:0]} : accessData};
               end
            end
            MODE_COMPRESSED: begin
               if (opcodeValid) begin
                  if (!r.baseValid || opcodePc[PC_MSB:PC_PAGE_LSB] !=
                        r.pcBase[PC_MSB:PC_PAGE_LSB]) begin
                     // flush the partial line ahead of the new base
                     wr1 = 1'b1; // R23
                     if (r.slotCnt != 2'h0) begin
                        wr2 = 1'b1;
                        lineA = {r.slotCnt, r.slots};
                        lineB = {INFO_BASE, opcodePc};
                     end else begin
                        lineA = {INFO_BASE, opcodePc};
                     end
                     next_r.pcBase = opcodePc;
                     next_r.baseValid = 1'b1;
                     next_r.slots = '0;
                     next_r.slotCnt = 2'h0;
                  end else if (r.slotCnt == 2'h2) begin
                     wr1 = 1'b1; // R23
                     lineA = {INFO_THREE, opcodePc[5:0], r.slots[11:0]};
                     next_r.slots = '0;
                     next_r.slotCnt = 2'h0;
                  end else begin
                     if (r.slotCnt == 2'h0) begin
                        next_r.slots[5:0] = opcodePc[5:0];
                     end else begin
                        next_r.slots[11:6] = opcodePc[5:0];
                     end
                     next_r.slotCnt = r.slotCnt + 2'h1;
                  end
               end
            end
            default: begin
               wr1 = 1'b0;
            end
         endcase
      end

      // pointer and count follow every stored line
      cnt = {1'b0, r.lineCount} + (wr2 ? 8'h02 : 8'h01);
      if (wr1) begin
         next_r.wrPtr = r.wrPtr + (wr2 ? 6'h02 : 6'h01); // R3 R14
         next_r.lineCount = (cnt >= {1'b0, COUNT_FULL}) ?
            COUNT_FULL : cnt[6:0]; // R5 R24
      end

      // sequencer side
      if (r.pendStart && isArmed) begin
         next_r.pendStart = 1'b0;
         next_r.state = ST_STORE; // R10
      end
      case (r.state)
         ST_IDLE: begin
            next_r.pendStart = 1'b0;
         end
         ST_WAIT: begin
            if (finalEnter) begin
               if (r.source && r.align) begin
                  next_r.state = ST_STORE; // R9
               end else begin
                  endSession = 1'b1; // R1 R2
               end
            end
         end
         ST_STORE: begin
            if (!r.align && finalEnter) begin
               endSession = 1'b1; // R8 R14
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
      // begin-aligned session runs until the store is full
      if (isArmed && r.align && r.source && wr1 &&
            next_r.lineCount == COUNT_FULL) begin
         endSession = 1'b1; // R11 R13
      end

      // ======================================================
      // register writes
      if (busWrite && adr_i == OFS_CONTROL_ONE) begin
         if ((dat_i[BIT_ARM] && !isArmed) || (dat_i[BIT_SOFTWARE_TRIGGER] &&
               r.source && r.align && !isArmed)) begin
            next_r.lineCount = COUNT_RESET;
            next_r.wrPtr = '0;
            next_r.lastValid = 1'b0;
            next_r.baseValid = 1'b0;
            next_r.slotCnt = 2'h0;
            next_r.slots = '0;
            next_r.state = ST_WAIT;
            next_r.pendStart = r.source & ~r.align; // R8 R10
         end
         if (dat_i[BIT_SOFTWARE_TRIGGER]) begin
            if (r.source && r.align) begin
               if (isArmed || dat_i[BIT_ARM]) begin
                  next_r.state = ST_WAIT;
                  next_r.pendStart = 1'b1; // R10
               end
            end else if (isArmed || dat_i[BIT_ARM]) begin
               endSession = 1'b1; // R1
            end
         end else if (!dat_i[BIT_ARM] && isArmed) begin
            next_r.state = ST_IDLE;
            next_r.pendStart = 1'b0;
         end
      end
      if (busWrite && adr_i == OFS_TRACE_CONTROL) begin
         next_r.mode = mode_type'(dat_i[1:0]); // R16
         next_r.align = dat_i[BIT_ALIGN];
         next_r.source = dat_i[BIT_SOURCE]; // R16
      end
      if (endSession) begin
         next_r.state = ST_IDLE; // R2
         next_r.pendStart = 1'b0;
         next_r.brk = 1'b1; // R1 R13
      end
      // oldest line is read first once disarmed
      if (isArmed && next_r.state == ST_IDLE) begin
         next_r.rdPtr = (next_r.lineCount == COUNT_FULL) ?
            next_r.wrPtr : 6'h00;
         next_r.highRead = 1'b0;
      end

      // ======================================================
      // register reads
      case (adr_i)
         OFS_CONTROL_ONE: begin
            rdValue = {8'h00, isArmed, 7'h00};
         end
         OFS_TRACE_CONTROL: begin
            rdValue = {12'h000, r.source, r.align, r.mode};
         end
         OFS_WINDOW_HIGH: begin
            rdValue = isArmed ? INVALID_READ :
               {12'h000, ram.rdData[19:16]}; // R7
            if (busRead && !isArmed) begin
               next_r.highRead = 1'b1; // R25
            end
         end
         OFS_WINDOW_LOW: begin
            rdValue = isArmed ? INVALID_READ : ram.rdData[15:0]; // R7
            if (busRead && !isArmed && r.highRead) begin
               next_r.rdPtr = r.rdPtr + 6'h01; // R4 R25
               next_r.highRead = 1'b0;
            end
         end
         OFS_LINE_COUNT: begin
            rdValue = {9'h000, r.lineCount};
         end
         default: begin
            rdValue = 16'h0000;
         end
      endcase
      next_r.dat = busRead ? {16'h0000, rdValue} : 32'h0000_0000;
      next_r.armedFlag = (next_r.state != ST_IDLE);
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         r <= '{state: ST_IDLE, mode: MODE_NORMAL, source: SOURCE_RESET,
            align: ALIGN_RESET, lineCount: COUNT_RESET, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign ram.we = wr1; // R3
   assign ram.we2 = wr2;
   assign ram.wrAddr = r.wrPtr;
   assign ram.wrData = lineA;
   assign ram.wrData2 = lineB;
   assign ram.rdAddr = r.rdPtr;

   assign dat_o = r.dat;
   assign ack_o = r.ack;
   assign armed = r.armedFlag;
   assign breakpointRequest = r.brk;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence armEndWrite;
      busWrite && adr_i == OFS_CONTROL_ONE && dat_i[BIT_ARM] &&
         !dat_i[BIT_SOFTWARE_TRIGGER] && !isArmed && r.source && !r.align;
   endsequence

   sequence finalNoBus;
      finalEnter && !busReq;
   endsequence

   chk_start_delay: // R10
      assert property (armEndWrite ##1 !finalEnter |=>
         r.state == ST_STORE)
      else $error("end-aligned storing not started two cycles on");

   chk_trace_off_brk: // R1
      assert property (r.state == ST_WAIT && !r.source ##0 finalNoBus
         |-> !wr1 ##1 (r.brk && r.state == ST_IDLE))
      else $error("final state with tracing off did not disarm");

   chk_end_disarm: // R14
      assert property (r.state == ST_STORE && !r.align ##0 finalNoBus
         |=> r.state == ST_IDLE && r.brk && !armed)
      else $error("end-aligned final state did not disarm");

   chk_bdm_quiet: // R6
      assert property (backgroundDebugActive |-> !wr1)
      else $error("line stored during background debug");

   chk_count_step: // R5
      assert property (wr1 && !wr2 && r.lineCount < 7'h3f &&
         !busWrite |=> r.lineCount == 7'($past(r.lineCount) + 7'h01))
      else $error("line count did not step by one");

   chk_armed_read: // R7
      assert property (busRead && adr_i == OFS_WINDOW_LOW && isArmed
         |=> $stable(r.rdPtr) && dat_o == {16'h0000, INVALID_READ})
      else $error("armed window read disturbed pointer");

   chk_line_pair: // R25
      assert property (busRead && adr_i == OFS_WINDOW_LOW &&
         r.highRead && !isArmed
         |=> r.rdPtr == 6'($past(r.rdPtr) + 6'h01))
      else $error("read pointer not advanced after full line");

   chk_begin_hold: // R11
      assert property (r.state == ST_WAIT && !finalEnter |-> !wr1)
      else $error("line stored before the trigger");

   chk_end_skip: // R15
      assert property (r.state == ST_STORE && !r.align && finalEnter
         |-> !wr1)
      else $error("end-aligned trigger entry stored");

   chk_detail_pair: // R24
      assert property (wr1 && r.mode == MODE_DETAIL |-> wr2)
      else $error("detail entry not two lines");

   chk_loop_filter: // R21
      assert property (wr1 && r.mode == MODE_LOOP &&
         cof_is_source(cofClass) |-> !(r.lastValid &&
         r.lastAddr == cofAddr))
      else $error("repeated source stored in loop mode");

endmodule: debug_trace_capture

// ### verification/cpu_trace_source.sv
// cpu side model: flow changes, data accesses and executed opcodes.
// assumes the bench calls its tasks from one process at a time.
module cpu_trace_source
   import trace_pkg::*;
(
   // clock
   input wire logic core_clk,
   // cpu activity
   output logic backgroundDebugActive,
   output logic cofValid,
   output trace_pkg::cof_class_type cofClass,
   output logic [17:0] cofAddr,
   output logic accessValid,
   output logic accessFetch,
   output logic accessByte,
   output logic accessRead,
   output logic [17:0] accessAddr,
   output logic [15:0] accessData,
   output logic opcodeValid,
   output logic [17:0] opcodePc
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {backgroundDebugActive, cofValid, accessValid, opcodeValid} = 4'h0;
      {accessFetch, accessByte, accessRead} = 3'h0;
      cofClass = COF_NONE;
      {cofAddr, accessAddr, opcodePc, accessData} = '0;
   end

   task automatic change_of_flow(input cof_class_type c, input logic [17:0] a);
      @(posedge core_clk);
      cofValid <= 1'h1;
      cofClass <= c;
      cofAddr <= a;
      @(posedge core_clk);
      cofValid <= 1'h0;
      // a released bus never keeps showing its last value
      cofAddr <= ~a;
   endtask: change_of_flow

   task automatic acc(input logic [2:0] fbr, input logic [17:0] a,
         input logic [15:0] d);
      @(posedge core_clk);
      accessValid <= 1'h1;
      {accessFetch, accessByte, accessRead} <= fbr;
      accessAddr <= a;
      accessData <= d;
      @(posedge core_clk);
      accessValid <= 1'h0;
      accessData <= ~d;
   endtask: acc

   task automatic op(input logic [17:0] pc);
      @(posedge core_clk);
      opcodeValid <= 1'h1;
      opcodePc <= pc;
      @(posedge core_clk);
      opcodeValid <= 1'h0;
      opcodePc <= ~pc;
   endtask: op

   task automatic bg(input logic v);
      @(posedge core_clk);
      backgroundDebugActive <= v;
   endtask: bg
endmodule: cpu_trace_source

// ### verification/tb.sv
// self-checking bench of the trace capture block.
// assumes the cpu model drives all cpu activity inputs.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import trace_pkg::*;

   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, finalEnter = 1'h0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [3:0] wrSel = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [19:0] l;
   logic ack_o, armed, breakpointRequest, backgroundDebugActive, cofValid;
   logic accessValid, accessFetch, accessByte, accessRead, opcodeValid;
   cof_class_type cofClass;
   logic [17:0] cofAddr, accessAddr, opcodePc;
   logic [15:0] accessData;
   int failures = 0, n_compared = 0;

   always #20 core_clk = ~core_clk;

   debug_trace_capture dut(.core_clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .finalEnter, .backgroundDebugActive,
      .cofValid, .cofClass, .cofAddr, .accessValid, .accessFetch,
      .accessByte, .accessRead, .accessAddr, .accessData, .opcodeValid,
      .opcodePc, .armed, .breakpointRequest);
   cpu_trace_source cpu(.core_clk, .backgroundDebugActive, .cofValid,
      .cofClass, .cofAddr, .accessValid, .accessFetch, .accessByte,
      .accessRead, .accessAddr, .accessData, .opcodeValid, .opcodePc);

   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask: check

   task automatic wb(input logic w, input logic [7:0] a,
         input logic [15:0] d, output logic [31:0] r);
      @(posedge core_clk);
      {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, wrSel};
      adr_i <= a;
      dat_i <= {16'h0000, d};
      // only the watchdog ends a wait for the answer
      do @(posedge core_clk);
      while (ack_o !== 1'h1);
      r = dat_o;
      {cyc_i, stb_i, we_i} <= 3'h0;
   endtask: wb

   task automatic rdline(output logic [19:0] r);
      logic [31:0] h;
      wb(1'h0, OFS_WINDOW_HIGH, 16'h0, h);
      wb(1'h0, OFS_WINDOW_LOW, 16'h0, q);
      r = {h[3:0], q[15:0]};
   endtask: rdline

   task automatic arm(input logic [15:0] tc);
      wb(1'h1, OFS_TRACE_CONTROL, tc, q);
      wb(1'h1, OFS_CONTROL_ONE, 16'h0080, q);
   endtask: arm

   task automatic fin();
      @(posedge core_clk);
      finalEnter <= 1'h1;
      @(posedge core_clk);
      finalEnter <= 1'h0;
   endtask: fin

   // session end: breakpoint seen within a few cycles, then disarmed
   task automatic endchk(input logic [6:0] cnt);
      logic s;
      s = 1'h0;
      repeat (4) begin
         #1 s |= (breakpointRequest === 1'h1);
         @(posedge core_clk);
      end
      check(s, 1);
      check(armed, 0);
      wb(1'h0, OFS_LINE_COUNT, 16'h0, q);
      check(q[6:0], cnt);
   endtask: endchk

   task automatic rst();
      @(posedge core_clk);
      reset <= 1'h1;
      repeat (2) @(posedge core_clk);
      reset <= 1'h0;
   endtask: rst

   // ==========================================================
   // scenarios
   task automatic end_normal();
      arm(16'h0008);
      cpu.change_of_flow(COF_COND_TAKEN, 18'h2abcd);
      cpu.change_of_flow(COF_UNCOND, 18'h00111);
      cpu.change_of_flow(COF_DIRECT, 18'h00222);
      cpu.change_of_flow(COF_BDM_VECTOR, 18'h3fff0);
      cpu.change_of_flow(COF_INDEXED, 18'h10001);
      cpu.change_of_flow(COF_RETURN, 18'h00010);
      cpu.change_of_flow(COF_VECTOR, 18'h3fff2);
      wb(1'h0, OFS_WINDOW_LOW, 16'h0, q);
      check(q, {16'h0, INVALID_READ});
      fork
         cpu.change_of_flow(COF_INDEXED, 18'h05555);
         fin();
      join
      endchk(7'h04);
      wb(1'h0, OFS_WINDOW_LOW, 16'h0, q);
      check(q[15:0], 16'habcd);
      rdline(l);
      check(l, {2'h0, 18'h2abcd});
      rdline(l);
      check(l, {2'h2, 18'h10001});
      rdline(l);
      check(l, {2'h2, 18'h00010});
      rdline(l);
      check(l, {2'h3, 18'h3fff2});
   endtask: end_normal

   task automatic disabled();
      arm(16'h0000);
      cpu.change_of_flow(COF_INDEXED, 18'h01111);
      fin();
      endchk(7'h00);
      wb(1'h0, OFS_CONTROL_ONE, 16'h0, q);
      check(q[BIT_ARM], 0);
   endtask: disabled

   task automatic loop_bg();
      arm(16'h0009);
      repeat (2) cpu.change_of_flow(COF_COND_TAKEN, 18'h00aa0);
      repeat (2) cpu.change_of_flow(COF_INDEXED, 18'h00bb0);
      cpu.bg(1'h1);
      cpu.change_of_flow(COF_INDEXED, 18'h00cc0);
      cpu.bg(1'h0);
      fin();
      endchk(7'h03);
   endtask: loop_bg

   task automatic detail();
      arm(16'h000a);
      cpu.acc(3'h4, 18'h00300, 16'h1111);
      cpu.acc(3'h3, 18'h01234, 16'h5a3c);
      fin();
      endchk(7'h02);
      rdline(l);
      check(l, {2'h3, 18'h01234});
      rdline(l);
      check(l, 20'h0003c);
   endtask: detail

   task automatic compressed();
      arm(16'h000b);
      cpu.op(18'h00100);
      cpu.op(18'h00102);
      cpu.op(18'h00104);
      cpu.op(18'h00200);
      fin();
      endchk(7'h03);
      rdline(l);
      check(l, {2'h0, 18'h00100});
      rdline(l);
      check(l, {2'h2, 6'h00, 6'h04, 6'h02});
   endtask: compressed

   task automatic begin_align();
      arm(16'h000c);
      cpu.change_of_flow(COF_INDEXED, 18'h00aaa);
      fork
         cpu.change_of_flow(COF_INDEXED, 18'h01234);
         fin();
      join
      #1 check(breakpointRequest, 0);
      for (int i = 1; i < 63; i++) cpu.change_of_flow(COF_RETURN, 18'(i));
      #1 check(armed, 1);
      cpu.change_of_flow(COF_RETURN, 18'h3ffff);
      endchk(COUNT_FULL);
      rdline(l);
      check(l, {2'h2, 18'h01234});
   endtask: begin_align

   // software trigger: begin mode starts storing, end mode ends the session
   task automatic soft_software_trigger();
      wb(1'h1, OFS_TRACE_CONTROL, 16'h000c, q);
      wrSel = 4'he;
      wb(1'h1, OFS_CONTROL_ONE, 16'h0080, q);
      wrSel = 4'hf;
      check(armed, 0);
      wb(1'h1, OFS_CONTROL_ONE, 16'h00c0, q);
      cpu.change_of_flow(COF_RETURN, 18'h00777);
      check(armed, 1);
      wb(1'h1, OFS_CONTROL_ONE, 16'h0000, q);
      wb(1'h0, OFS_LINE_COUNT, 16'h0, q);
      check(q[6:0], 1);
      rdline(l);
      check(l, {2'h2, 18'h00777});
      arm(16'h0008);
      fork
         wb(1'h1, OFS_CONTROL_ONE, 16'h0040, q);
         endchk(7'h00);
      join
   endtask: soft_software_trigger

   // ==========================================================
   // run control
   task automatic print_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask: print_verdict

   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 1'h0;
      wb(1'h0, 8'ha0, 16'h0, q);
      check(q, 0);
      check(armed, 0);
      end_normal();
      rst();
      disabled();
      rst();
      loop_bg();
      rst();
      detail();
      rst();
      compressed();
      rst();
      begin_align();
      rst();
      soft_software_trigger();
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      print_verdict();
   end
endmodule: tb
